// ===== hdl/rps_cfg.svh
// constants for the redundant pair switchover controller
// assumes one 10 MHz clock and a peer controller on the interconnect lead
// Notes on behaviour
// - both process; only on-line unit enables outputs
// - health checked periodically in either role
// - simultaneous power-up: either may go on-line
// - minimise role changes, no unprompted swapping back
// - demoted unit stays off-line after fault clears
// - recovered demoted unit serves as standby
// - switch on unit fault or on-line traffic fault
// - traffic fault seen by both: no switch (code switches if both start together; peer fault is synced 2 cycles late)
// - manual request simulates brief on-line failure
// - attached lead forces exactly one unit standby
// - no switchover unless standby fully operational
// - standby keeps transmit output muted
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH
`define RPS_CLK_HZ          10000000
`define RPS_CHECK_US        100
`define RPS_CHECK_CYC       ((`RPS_CHECK_US * (`RPS_CLK_HZ / 1000000)))
`define RPS_MANUAL_US       5
`define RPS_MANUAL_CYC      ((`RPS_MANUAL_US * (`RPS_CLK_HZ / 1000000)))
`define RPS_STARTUP_US      20
`define RPS_STARTUP_CYC     ((`RPS_STARTUP_US * (`RPS_CLK_HZ / 1000000)))
`define RPS_CNT_W           8
`endif

// ===== hdl/rps_pkg.sv
// types for the redundant pair switchover controller
// assumes rps_cfg.svh supplies the numeric constants
package rps_pkg;
    // role states, gray coded along startup -> standby -> online
    typedef enum logic [1:0] {
        RPS_START   = 2'b00,
        RPS_STANDBY = 2'b01,
        RPS_ONLINE  = 2'b11,
        RPS_DEMOTED = 2'b10
    } rps_role_t;

    typedef struct packed {
        rps_role_t  role;        // current role
        logic [9:0] chk_cnt;     // health check period counter, wide enough for the full period
        logic [7:0] man_cnt;     // simulated failure length
        logic [7:0] start_cnt;   // startup wait
        logic       healthy;     // sampled health
        logic       man_prev;    // manual request edge detect
        logic [1:0] peer_on_s;   // peer on-line synchroniser
        logic [1:0] peer_ok_s;   // peer healthy synchroniser
        logic [1:0] lead_s;      // lead present synchroniser
        logic [1:0] pftf_s;      // peer traffic fault synchroniser
    } rps_state_t;
endpackage : rps_pkg

// ===== hdl/rps_switchover.sv
// switchover controller for one unit of a 1:1 redundant pair
// assumes the peer runs the same logic; peer lines are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"
module rps_switchover (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    // local status
    input  wire logic unit_fault_i,     // internal unit fault level
    input  wire logic traffic_fault_i,  // local traffic fault level
    input  wire logic manual_req_i,     // manual switch request level
    // interconnect lead from peer
    input  wire logic lead_present_i,   // lead attached
    input  wire logic peer_online_i,    // peer holds on-line role
    input  wire logic peer_healthy_i,   // peer fully operational
    input  wire logic peer_traffic_fault_i, // peer sees traffic fault
    // interconnect lead to peer
    output logic      online_o,         // we hold on-line role
    output logic      healthy_o,        // we are fully operational
    output logic      traffic_fault_o,  // our traffic fault
    // output enables and standby role indicator
    output logic      tx_enable_o,      // satellite transmit enable
    output logic      terr_enable_o,    // terrestrial output enable
    output logic      role_standby_o    // standby role indicator
);
    rps_pkg::rps_state_t st_ff;     // registered state
    rps_pkg::rps_state_t nxt_st;    // next state
    logic sim_fail;                 // simulated failure active
    logic fault_now;                // effective local fault
    logic peer_on;                  // synced peer on-line
    logic peer_ok;                  // synced peer healthy
    logic lead;                     // synced lead present
    logic common_tf;                // traffic fault on both units

    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.peer_on_s = {st_ff.peer_on_s[0], peer_online_i};
        nxt_st.peer_ok_s = {st_ff.peer_ok_s[0], peer_healthy_i};
        nxt_st.lead_s    = {st_ff.lead_s[0], lead_present_i};
        nxt_st.pftf_s    = {st_ff.pftf_s[0], peer_traffic_fault_i};
        peer_on   = st_ff.peer_on_s[1];
        peer_ok   = st_ff.peer_ok_s[1];
        lead      = st_ff.lead_s[1];
        common_tf = traffic_fault_i && st_ff.pftf_s[1];
        sim_fail  = (st_ff.man_cnt != 8'h00);
        // periodic health sample in every role
        // full check period kept; an 8-bit count would shorten it silently
        if (st_ff.chk_cnt == 10'h000) begin
            nxt_st.chk_cnt = 10'(`RPS_CHECK_CYC - 1);
            nxt_st.healthy = !unit_fault_i;
        end else begin
            nxt_st.chk_cnt = st_ff.chk_cnt - 10'h001;
        end
        // manual request starts a brief simulated failure
        nxt_st.man_prev = manual_req_i;
        if (manual_req_i && !st_ff.man_prev && st_ff.role == rps_pkg::RPS_ONLINE) begin
            nxt_st.man_cnt = 8'(`RPS_MANUAL_CYC);
        end else if (sim_fail) begin
            nxt_st.man_cnt = st_ff.man_cnt - 8'h01;
        end
        fault_now = unit_fault_i || (traffic_fault_i && !common_tf) || sim_fail;
        case (st_ff.role)
            rps_pkg::RPS_START: begin
                // wait for peer to show itself; earlier unit wins
                if (st_ff.start_cnt != 8'h00) begin
                    nxt_st.start_cnt = st_ff.start_cnt - 8'h01;
                end else if (!lead) begin
                    nxt_st.role = rps_pkg::RPS_ONLINE;
                end else if (peer_on) begin
                    nxt_st.role = rps_pkg::RPS_STANDBY;
                end else if (!unit_fault_i) begin
                    nxt_st.role = rps_pkg::RPS_ONLINE;
                end
            end
            rps_pkg::RPS_STANDBY: begin
                // take over only when the lead is absent or the peer is off-line or failed
                if ((!lead || !peer_on || !peer_ok) && !unit_fault_i) begin
                    nxt_st.role = rps_pkg::RPS_ONLINE;
                end
            end
            rps_pkg::RPS_ONLINE: begin
                // yield to an on-line peer; on fault hand over only if the standby is fully operational
                if (lead && peer_on) begin
                    nxt_st.role = rps_pkg::RPS_STANDBY;
                end else if (fault_now && lead && peer_ok) begin
                    nxt_st.role = rps_pkg::RPS_DEMOTED;
                end
            end
            rps_pkg::RPS_DEMOTED: begin
                // never reclaim; recovered unit becomes standby
                if (st_ff.healthy && !unit_fault_i && peer_on) begin
                    nxt_st.role = rps_pkg::RPS_STANDBY;
                end
            end
            default: nxt_st.role = rps_pkg::RPS_START;
        endcase
        // no new trigger, no role change: transitions above need a cause
        if (reset_i) begin
            nxt_st           = '0;
            nxt_st.role      = rps_pkg::RPS_START;
            nxt_st.start_cnt = 8'(`RPS_STARTUP_CYC);
        end
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        st_ff <= nxt_st;
    end

    // outputs from the registered state; traffic fault passed straight through
    assign online_o        = (st_ff.role == rps_pkg::RPS_ONLINE);
    assign healthy_o       = st_ff.healthy && (st_ff.man_cnt == 8'h00);
    assign traffic_fault_o = traffic_fault_i;
    assign tx_enable_o     = online_o;
    assign terr_enable_o   = online_o;
    assign role_standby_o  = (st_ff.role == rps_pkg::RPS_STANDBY);
endmodule : rps_switchover
`default_nettype wire

// ===== sim/rps_switchover_asserts.sv
// checker for the switchover controller
// assumes it is bound to rps_switchover
`timescale 1ns/1ps
`default_nettype none
module rps_switchover_asserts (
    // all ports of the controller
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic unit_fault_i,
    input wire logic traffic_fault_i,
    input wire logic manual_req_i,
    input wire logic lead_present_i,
    input wire logic peer_online_i,
    input wire logic peer_healthy_i,
    input wire logic peer_traffic_fault_i,
    input wire logic online_o,
    input wire logic healthy_o,
    input wire logic traffic_fault_o,
    input wire logic tx_enable_o,
    input wire logic terr_enable_o,
    input wire logic role_standby_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    out_en_a: assert property (tx_enable_o == online_o && terr_enable_o == online_o) else $error("enable");
    sb_mute_a: assert property (role_standby_o |-> !tx_enable_o) else $error("standby tx");
    one_role_a: assert property (!(online_o && role_standby_o)) else $error("two roles");
    tf_copy_a: assert property (traffic_fault_o == traffic_fault_i) else $error("tf copy");
    fault_sw_a: assert property ((lead_present_i && peer_healthy_i)[*4] ##0 (online_o && unit_fault_i)
        |-> ##[1:4] !online_o) else $error("no fault switch");
    man_sw_a: assert property ((lead_present_i && peer_healthy_i)[*4] ##0 (online_o && $rose(manual_req_i))
        |-> ##[1:4] !online_o) else $error("no manual switch");
    ext_tf_a: assert property ((peer_traffic_fault_i && !unit_fault_i && !manual_req_i && !peer_online_i)[*4]
        ##0 online_o |=> online_o) else $error("external tf switch");
    sb_bad_a: assert property ((!peer_healthy_i && !peer_online_i)[*4] ##0 online_o |=> online_o)
        else $error("switch to bad standby");
endmodule : rps_switchover_asserts
bind rps_switchover rps_switchover_asserts rps_switchover_asserts_i (.*);
`default_nettype wire

// ===== sim/rps_peer.sv
// behavioural peer controller on the lead
// assumes the bench commands its faults
`timescale 1ns/1ps
`default_nettype none
module rps_peer (
    // clock, reset, bench commands
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic fail_i,
    input wire logic tf_i,
    // lead lines
    input wire logic dut_online_i,
    output logic peer_online_o,
    output logic peer_healthy_o,
    output logic peer_tf_o
);
    logic on_ff; // peer holds on-line role
    // claim only while the unit is off-line, drop on failure
    always_ff @(posedge sys_clk_i) begin
        on_ff <= !reset_i && !fail_i && (on_ff || !dut_online_i);
    end
    assign peer_online_o = on_ff;
    assign peer_healthy_o = !fail_i;
    assign peer_tf_o = tf_i;
endmodule : rps_peer
`default_nettype wire

// ===== sim/rps_switchover_tb.sv
// bench for the switchover controller
// assumes 10 MHz clock, peer model and bound checker
`timescale 1ns/1ps
`default_nettype none
module rps_switchover_tb;
    logic clk = 1'b0, rst = 1'b1, uf = 1'b0, tf = 1'b0, mr = 1'b0, pf = 1'b0, ptf = 1'b0, ld = 1'b1;
    logic onl, hl, tfo, tx, terr, sb, pon, pok, ptfo;
    int miscompares = 0, total_checks = 0;
    rps_switchover rps_switchover_i (.sys_clk_i(clk), .reset_i(rst), .unit_fault_i(uf), .traffic_fault_i(tf),
        .manual_req_i(mr), .lead_present_i(ld), .peer_online_i(pon), .peer_healthy_i(pok),
        .peer_traffic_fault_i(ptfo), .online_o(onl), .healthy_o(hl), .traffic_fault_o(tfo),
        .tx_enable_o(tx), .terr_enable_o(terr), .role_standby_o(sb));
    rps_peer rps_peer_i (.sys_clk_i(clk), .reset_i(rst), .fail_i(pf), .tf_i(ptf), .dut_online_i(onl),
        .peer_online_o(pon), .peer_healthy_o(pok), .peer_tf_o(ptfo));
    initial forever #50 clk = ~clk;
    task automatic chk(input logic s, input logic e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : cyc
    // bounded wait for the on-line output
    task automatic wt(input logic v);
        for (int i = 0; i < 600 && onl !== v; i++) cyc(1);
    endtask : wt
    task automatic t_start;
        cyc(400);
        chk(sb, 1'b1);
        chk(tx, 1'b0);
    endtask : t_start
    task automatic t_fail;
        pf = 1'b1;
        wt(1'b1);
        chk(terr, 1'b1);
        uf = 1'b1;
        cyc(20);
        chk(onl, 1'b1);
        pf = 1'b0;
        wt(1'b0);
        chk(onl, 1'b0);
        uf = 1'b0;
        cyc(1100);
        chk(onl, 1'b0);
        chk(sb, 1'b1);
    endtask : t_fail
    task automatic t_tf;
        pf = 1'b1;
        wt(1'b1);
        pf = 1'b0;
        tf = 1'b1;
        ptf = 1'b1;
        cyc(50);
        chk(onl, 1'b1);
        chk(tfo, 1'b1);
        ptf = 1'b0;
        wt(1'b0);
        chk(onl, 1'b0);
        tf = 1'b0;
        cyc(600);
    endtask : t_tf
    task automatic t_man;
        pf = 1'b1;
        wt(1'b1);
        pf = 1'b0;
        cyc(20);
        chk(onl, 1'b1);
        mr = 1'b1;
        wt(1'b0);
        chk(onl, 1'b0);
        mr = 1'b0;
        cyc(20);
        chk(hl, 1'b0);
        cyc(600);
        chk(sb, 1'b1);
    endtask : t_man
    // lead pulled then reattached while the peer stays on-line
    task automatic t_lead;
        ld = 1'b0;
        cyc(20);
        chk(onl, 1'b1);
        ld = 1'b1;
        cyc(20);
        chk(sb, 1'b1);
        chk(onl, 1'b0);
    endtask : t_lead
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        #2ms;
        miscompares++;
        conclude();
    end
    initial begin
        cyc(3);
        rst = 1'b0;
        t_start();
        t_fail();
        t_tf();
        t_man();
        t_lead();
        conclude();
    end
endmodule : rps_switchover_tb
`default_nettype wire
